// file: rtl/ssnc_pkg.sv
// Constants, state codes and carrier types of the structured sequence number checker.
// Overview of operation
// - Start discards all; valid number goes unlocked.
// - Unlocked: invalid to start, out-of-order discarded.
// - Unlocked in-order cell accepted, becomes locked.
// - Locked in-order cell accepted, signalling update allowed.
// - Locked invalid number accepted, go after-bad, silently.
// - Locked gap accepted, gap flagged, go after-gap.
// - After-bad: misinsertion discarded, flagged, relock; invalid restarts.
// - After-bad: two ahead of good accepted, relock.
// - After-bad: other valid cell discarded, go unlocked.
// - After-gap: misinsertion discarded, flagged, relock; invalid restarts.
// - After-gap: loss inserts up to six dummies, relocks.
// - After-gap: two ahead of good accepted, relock.
// - After-gap: other valid cell discarded, go unlocked.
// - Dummies only follow the accepted out-of-order cell.
// - Dummy payload comes from user fill data.
package ssnc_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_CONN = 16;                 // Connections tracked.
    localparam int CONN_W   = 4;                  // Connection index width.
    localparam int SN_W     = 3;                  // Sequence numbers count modulo eight.
    localparam int PAY_W    = 376;                // One 47-byte cell payload.

    // ------------------------------------------------------------
    // Counts and reset values
    // ------------------------------------------------------------
    localparam logic [SN_W-1:0] SN_STEP1 = 3'h1;  // One ahead.
    localparam logic [SN_W-1:0] SN_STEP2 = 3'h2;  // Two ahead.
    localparam logic [SN_W-1:0] MAX_LOST = 3'h6;  // Most dummies for one loss.
    localparam logic [SN_W-1:0] SN_RST   = 3'h0;  // Stored numbers after reset.

    // ------------------------------------------------------------
    // Checker states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        S_RESET  = 6'h01,
        S_START  = 6'h02,
        S_UNLOCK = 6'h04,
        S_LOCK   = 6'h08,
        S_BAD    = 6'h10,
        S_GAP    = 6'h20
    } ssnc_state_t;

    // Received cell as offered by the receive path.
    typedef struct packed {
        logic [CONN_W-1:0] conn;
        logic [SN_W-1:0]   sn;
        logic              sn_ok;
        logic [PAY_W-1:0]  payload;
    } ssnc_cell_t;

    // Cell handed to the reassembly buffer writer.
    typedef struct packed {
        logic [CONN_W-1:0] conn;
        logic [PAY_W-1:0]  payload;
        logic              dummy;
        logic              cas_ok;
    } ssnc_out_t;

endpackage : ssnc_pkg

// file: rtl/ssnc_fsm.sv
// Structured-mode sequence number checker with dummy cell insertion and output buffer.
module ssnc_fsm (
    input  wire logic                       mclk,
    input  wire logic                       arst_n,
    input  wire logic                       in_valid,
    input  wire ssnc_pkg::ssnc_cell_t       in_cell,
    output logic                            in_ready,
    input  wire logic [ssnc_pkg::PAY_W-1:0] fill_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output ssnc_pkg::ssnc_out_t             out_cell,
    output logic                            discard_flag,
    output logic                            seq_gap_flag,
    output logic                            misinsert_flag,
    output logic                            lost_cell_flag,
    output logic [ssnc_pkg::SN_W-1:0]       lost_count
);

    // ------------------------------------------------------------
    // Per-connection memory
    // ------------------------------------------------------------
    ssnc_pkg::ssnc_state_t           st_mem   [ssnc_pkg::NUM_CONN]; // Checker state.
    logic [ssnc_pkg::SN_W-1:0]       rx_mem   [ssnc_pkg::NUM_CONN]; // Last received number.
    logic [ssnc_pkg::SN_W-1:0]       good_mem [ssnc_pkg::NUM_CONN]; // Last good number.
    logic                            boot;                          // First cycle after reset.

    // ------------------------------------------------------------
    // Emitter and buffer state
    // ------------------------------------------------------------
    logic                            pend;       // A decided cell waits to be emitted.
    ssnc_pkg::ssnc_cell_t            pend_cell;  // The accepted cell itself.
    logic                            pend_cas;   // Signalling update allowed for it.
    logic [ssnc_pkg::SN_W-1:0]       dum_left;   // Dummies still to be emitted first.
    ssnc_pkg::ssnc_out_t             skid;       // Second buffer entry.
    logic                            skid_v;     // Second entry holds a word.

    // ------------------------------------------------------------
    // Decode of the offered cell
    // ------------------------------------------------------------
    wire logic                       take      = in_valid & in_ready;
    wire ssnc_pkg::ssnc_state_t      cur_st    = st_mem[in_cell.conn];
    wire logic [ssnc_pkg::SN_W-1:0]  lrx       = rx_mem[in_cell.conn];
    wire logic [ssnc_pkg::SN_W-1:0]  lgd       = good_mem[in_cell.conn];
    wire logic [ssnc_pkg::SN_W-1:0]  rx_next   = lrx + ssnc_pkg::SN_STEP1;
    wire logic [ssnc_pkg::SN_W-1:0]  gd_next   = lgd + ssnc_pkg::SN_STEP1;
    wire logic [ssnc_pkg::SN_W-1:0]  gd_next2  = lgd + ssnc_pkg::SN_STEP2;
    wire logic [ssnc_pkg::SN_W-1:0]  gap_cnt   = in_cell.sn - lgd - ssnc_pkg::SN_STEP2;
    wire logic                       ok        = in_cell.sn_ok;
    wire logic                       seq_rx    = ok & (in_cell.sn == rx_next);
    wire logic                       seq_gd    = ok & (in_cell.sn == gd_next);
    wire logic                       ahead2    = ok & (in_cell.sn == gd_next2);
    // The loss count saturates: more than six missing cells cannot be told apart.
    wire logic [ssnc_pkg::SN_W-1:0]  lost_calc = (gap_cnt > ssnc_pkg::MAX_LOST) ?
                                                 ssnc_pkg::MAX_LOST : gap_cnt;

    // ------------------------------------------------------------
    // Decision for one cell
    // ------------------------------------------------------------
    ssnc_pkg::ssnc_state_t           next_st;    // State after this cell.
    logic                            acc;        // Cell goes to reassembly.
    logic                            gap_err;    // Sequence gap seen.
    logic                            mis_err;    // Misinsertion seen.
    logic                            lost_err;   // Cell loss seen.
    logic                            cas;        // Signalling update allowed.
    logic                            upd_good;   // Store number as last good.
    logic [ssnc_pkg::SN_W-1:0]       n_dummy;    // Dummies to insert before cell.

    // One case per state; every valid number also becomes the last received one.
    always_comb begin
        next_st  = cur_st;
        acc      = 1'b0;
        gap_err  = 1'b0;
        mis_err  = 1'b0;
        lost_err = 1'b0;
        cas      = 1'b0;
        upd_good = 1'b0;
        n_dummy  = '0;
        unique case (cur_st)
            ssnc_pkg::S_START: begin
                // Hunting: nothing is passed, a valid number seeds both histories.
                if (ok) begin
                    next_st  = ssnc_pkg::S_UNLOCK;
                    upd_good = 1'b1;
                end
            end
            ssnc_pkg::S_UNLOCK: begin
                if (!ok) begin
                    next_st = ssnc_pkg::S_START;
                end else if (seq_rx) begin
                    acc     = 1'b1;
                    next_st = ssnc_pkg::S_LOCK;
                end
                upd_good = ok;
            end
            ssnc_pkg::S_LOCK: begin
                // Locked cells always go through; the follow-up state, gap flag and signalling update differ.
                acc = 1'b1;
                if (!ok) begin
                    next_st = ssnc_pkg::S_BAD;
                end else if (seq_rx) begin
                    cas      = 1'b1;
                    upd_good = 1'b1;
                end else begin
                    gap_err = 1'b1;
                    next_st = ssnc_pkg::S_GAP;
                end
            end
            ssnc_pkg::S_BAD: begin
                if (!ok) begin
                    next_st = ssnc_pkg::S_START;
                end else if (seq_gd) begin
                    mis_err = 1'b1;
                    next_st = ssnc_pkg::S_LOCK;
                end else if (ahead2) begin
                    acc     = 1'b1;
                    next_st = ssnc_pkg::S_LOCK;
                end else begin
                    next_st = ssnc_pkg::S_UNLOCK;
                end
                upd_good = ok;
            end
            ssnc_pkg::S_GAP: begin
                if (!ok) begin
                    next_st = ssnc_pkg::S_START;
                end else if (seq_gd) begin
                    mis_err = 1'b1;
                    next_st = ssnc_pkg::S_LOCK;
                end else if (seq_rx) begin
                    // The gap cell was already passed; dummies go after it.
                    lost_err = 1'b1;
                    n_dummy  = lost_calc;
                    acc      = 1'b1;
                    next_st  = ssnc_pkg::S_LOCK;
                end else if (ahead2) begin
                    acc     = 1'b1;
                    next_st = ssnc_pkg::S_LOCK;
                end else begin
                    next_st = ssnc_pkg::S_UNLOCK;
                end
                upd_good = ok;
            end
            ssnc_pkg::S_RESET: begin
                // Only seen if a cell races the boot cycle, which in_ready prevents.
                next_st = ssnc_pkg::S_START;
            end
            default: begin
                // A corrupted code falls back to hunting.
                next_st = ssnc_pkg::S_START;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Emitter: dummies first, then the cell
    // ------------------------------------------------------------
    wire logic                       buf_rdy   = ~skid_v;
    wire logic                       push_dum  = dum_left != '0;
    wire logic                       push_fire = pend & buf_rdy;
    wire ssnc_pkg::ssnc_out_t        push_data = push_dum ?
        ssnc_pkg::ssnc_out_t'{conn: pend_cell.conn, payload: fill_data, dummy: 1'b1,
                              cas_ok: 1'b0} :
        ssnc_pkg::ssnc_out_t'{conn: pend_cell.conn, payload: pend_cell.payload,
                              dummy: 1'b0, cas_ok: pend_cas};
    wire logic                       next_pend = take ? acc :
                                                 (pend & ~(push_fire & ~push_dum));

    // Checker memory; reset puts every connection in the reset state.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < ssnc_pkg::NUM_CONN; i++) begin
                st_mem[i]   <= ssnc_pkg::S_RESET;
                rx_mem[i]   <= ssnc_pkg::SN_RST;
                good_mem[i] <= ssnc_pkg::SN_RST;
            end
        end else if (boot) begin
            for (int i = 0; i < ssnc_pkg::NUM_CONN; i++) begin
                st_mem[i] <= ssnc_pkg::S_START;
            end
        end else if (take) begin
            st_mem[in_cell.conn] <= next_st;
            if (ok) begin
                rx_mem[in_cell.conn] <= in_cell.sn;
            end
            if (upd_good) begin
                good_mem[in_cell.conn] <= in_cell.sn;
            end
        end
    end

    // Boot marker and ready; ready stays low while a cell is being emitted.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            boot     <= 1'b1;
            in_ready <= 1'b0;
        end else begin
            boot     <= 1'b0;
            in_ready <= ~next_pend;
        end
    end

    // Pending cell and dummy countdown.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pend      <= 1'b0;
            pend_cell <= '0;
            pend_cas  <= 1'b0;
            dum_left  <= '0;
        end else begin
            pend <= next_pend;
            if (take) begin
                pend_cell <= in_cell;
                pend_cas  <= cas;
                dum_left  <= n_dummy;
            end else if (push_fire && push_dum) begin
                dum_left <= dum_left - ssnc_pkg::SN_STEP1;
            end
        end
    end

    // Event pulses, one cycle after the cell is taken.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            discard_flag   <= 1'b0;
            seq_gap_flag   <= 1'b0;
            misinsert_flag <= 1'b0;
            lost_cell_flag <= 1'b0;
            lost_count     <= '0;
        end else begin
            discard_flag   <= take & ~acc;
            seq_gap_flag   <= take & gap_err;
            misinsert_flag <= take & mis_err;
            lost_cell_flag <= take & lost_err;
            lost_count     <= take ? n_dummy : '0;
        end
    end

    // ------------------------------------------------------------
    // Two-entry output buffer
    // ------------------------------------------------------------
    // The head register drives the port; the skid entry catches a word pushed
    // during a stall, and its fullness alone stalls the emitter.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            out_valid <= 1'b0;
            out_cell  <= '0;
            skid_v    <= 1'b0;
            skid      <= '0;
        end else if (!out_valid || out_ready) begin
            if (skid_v) begin
                out_cell  <= skid;
                out_valid <= 1'b1;
                skid_v    <= 1'b0;
            end else begin
                out_valid <= push_fire;
                if (push_fire) begin
                    out_cell <= push_data;
                end
            end
        end else if (push_fire) begin
            skid   <= push_data;
            skid_v <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_boot;
        @(posedge mclk) disable iff (!arst_n) boot |=> !boot && in_ready;
    endproperty
    a_boot: assert property (p_boot) else $error("Not ready after boot");

    property p_start;
        @(posedge mclk) disable iff (!arst_n)
            take && cur_st == ssnc_pkg::S_START |=> discard_flag;
    endproperty
    a_start: assert property (p_start) else $error("Start passed a cell");

    property p_unl_drop;
        @(posedge mclk) disable iff (!arst_n)
            take && cur_st == ssnc_pkg::S_UNLOCK && !seq_rx |=> discard_flag && in_ready;
    endproperty
    a_unl_drop: assert property (p_unl_drop) else $error("Unlocked kept bad cell");

    property p_unl_acc;
        @(posedge mclk) disable iff (!arst_n)
            take && cur_st == ssnc_pkg::S_UNLOCK && seq_rx |=> !discard_flag ##1 out_valid;
    endproperty
    a_unl_acc: assert property (p_unl_acc) else $error("Unlocked lost good cell");

    property p_lock_cas;
        @(posedge mclk) disable iff (!arst_n)
            take && cur_st == ssnc_pkg::S_LOCK && seq_rx |=> pend && pend_cas;
    endproperty
    a_lock_cas: assert property (p_lock_cas) else $error("No signalling update");

    property p_lock_bad;
        @(posedge mclk) disable iff (!arst_n)
            take && cur_st == ssnc_pkg::S_LOCK && !ok |=> !discard_flag && !seq_gap_flag;
    endproperty
    a_lock_bad: assert property (p_lock_bad) else $error("Locked bad number wrong");

    property p_lock_gap;
        @(posedge mclk) disable iff (!arst_n)
            take && cur_st == ssnc_pkg::S_LOCK && ok && !seq_rx |=> seq_gap_flag && pend;
    endproperty
    a_lock_gap: assert property (p_lock_gap) else $error("Gap not flagged");

    property p_misins;
        @(posedge mclk) disable iff (!arst_n)
            take && cur_st == ssnc_pkg::S_BAD && seq_gd |=> misinsert_flag && discard_flag;
    endproperty
    a_misins: assert property (p_misins) else $error("Misinsertion missed");

    property p_lost;
        @(posedge mclk) disable iff (!arst_n)
            take && cur_st == ssnc_pkg::S_GAP && seq_rx && !seq_gd
            |=> lost_cell_flag && lost_count == $past(lost_calc) && dum_left == lost_count;
    endproperty
    a_lost: assert property (p_lost) else $error("Lost count wrong");

    property p_fill;
        @(posedge mclk) disable iff (!arst_n)
            out_valid && out_cell.dummy |-> !out_cell.cas_ok && out_cell.payload == fill_data;
    endproperty
    a_fill: assert property (p_fill) else $error("Dummy cell malformed");

endmodule : ssnc_fsm

// file: dv/ssnc_src.sv
// Behavioural receive path that offers queued cells to the checker.
module ssnc_src (
    input  wire logic            mclk,
    input  wire logic            in_ready,
    output logic                 in_valid,
    output ssnc_pkg::ssnc_cell_t in_cell
);
    timeunit 1ns;
    timeprecision 1ps;

    ssnc_pkg::ssnc_cell_t q[$];  // Cells waiting to be offered, filled by the bench.
    logic                 rdy_seen;  // Ready as settled before the coming edge.
    logic                 taken;     // The held cell went in at this edge.

    initial begin
        in_valid = 1'b0;
        in_cell  = '0;
        rdy_seen = 1'b0;
    end

    // Offer cells just after each edge; gaps are random so slow senders are covered.
    // A held cell never changes until it is taken, and idle data is inverted so a
    // design that samples without valid sees garbage rather than a stale copy.
    always begin
        @(posedge mclk);
        taken = in_valid && rdy_seen;
        #1;
        if (taken && q.size() > 0) begin
            void'(q.pop_front());
        end
        if (q.size() > 0 && ((in_valid && !taken) || $urandom % 4 != 0)) begin
            in_valid = 1'b1;
            in_cell  = q[0];
        end else begin
            in_valid = 1'b0;
            in_cell  = ~in_cell;
        end
        rdy_seen = in_ready;
    end
endmodule : ssnc_src

// file: dv/ssnc_fsm_bench.sv
// Self-checking bench of the structured sequence number checker.
module ssnc_fsm_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals and reference model state
    // ------------------------------------------------------------
    logic                       mclk, arst_n, in_valid, in_ready, out_valid, out_ready;
    logic                       discard_flag, seq_gap_flag, misinsert_flag, lost_cell_flag;
    logic [2:0]                 lost_count;
    logic [ssnc_pkg::PAY_W-1:0] fill_data;
    ssnc_pkg::ssnc_cell_t       in_cell;
    ssnc_pkg::ssnc_out_t        out_cell;
    ssnc_pkg::ssnc_out_t        exp_q[$];  // Words the buffer writer should see, in order.
    logic [6:0]                 exp_fl;    // Expected {discard, gap, misinsert, lost, count}.
    int                         mismatches, checks_done, stall, i;
    int                         st[16], lr[16], lg[16];  // 0 start 1 unlock 2 lock 3 bad 4 gap.
    int seq_a[] = '{1, 2, 3, 4, -1, 5, -1, 7, -1, 2, -1};
    int seq_b[] = '{0, 1, 2, 6, 7, 0, 4, 1, 3, 3, 6, 0, -1};
    int seq_c[] = '{0, 1, 2, 1, 2, 5, -1};

    ssnc_fsm ssnc_fsm_i (.mclk(mclk), .arst_n(arst_n), .in_valid(in_valid), .in_cell(in_cell),
        .in_ready(in_ready), .fill_data(fill_data), .out_valid(out_valid),
        .out_ready(out_ready), .out_cell(out_cell), .discard_flag(discard_flag),
        .seq_gap_flag(seq_gap_flag), .misinsert_flag(misinsert_flag),
        .lost_cell_flag(lost_cell_flag), .lost_count(lost_count));
    ssnc_src ssnc_src_i (.mclk(mclk), .in_ready(in_ready), .in_valid(in_valid),
        .in_cell(in_cell));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Comparison and closing tasks
    // ------------------------------------------------------------
    task automatic cmp_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: level got %b exp %b", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic cmp_flags(input logic [6:0] got, input logic [6:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: flags got %h exp %h", $time, got, exp);
        end
    endtask : cmp_flags

    task automatic cmp_word(input ssnc_pkg::ssnc_out_t got, input ssnc_pkg::ssnc_out_t exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: word conn %h dummy %b, exp %h %b", $time, got.conn,
                     got.dummy, exp.conn, exp.dummy);
        end
    endtask : cmp_word

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    // Reference model of one taken cell, run at the take edge.
    task automatic predict(input ssnc_pkg::ssnc_cell_t c);
        int                  k, s, n, acc, cas;
        ssnc_pkg::ssnc_out_t w;
        k      = c.conn;
        s      = c.sn;
        acc    = 0;
        cas    = 0;
        n      = 0;
        exp_fl = '0;
        if (!c.sn_ok) begin
            acc   = (st[k] == 2);
            st[k] = (st[k] == 2) ? 3 : 0;
        end else begin
            case (st[k])
                0: st[k] = 1;
                1: if (s == ((lr[k] + 1) & 7)) begin
                    acc   = 1;
                    st[k] = 2;
                end
                2: begin
                    acc = 1;
                    if (s == ((lr[k] + 1) & 7)) cas = 1;
                    else begin
                        exp_fl[5] = 1'b1;
                        st[k]     = 4;
                    end
                end
                default: begin
                    if (s == ((lg[k] + 1) & 7)) begin
                        exp_fl[4] = 1'b1;
                        st[k]     = 2;
                    end else if (st[k] == 4 && s == ((lr[k] + 1) & 7)) begin
                        n   = (s - lg[k] - 2) & 7;
                        n   = (n > 6) ? 6 : n;
                        acc = 1;
                        st[k] = 2;
                        exp_fl[3]   = 1'b1;
                        exp_fl[2:0] = n[2:0];
                    end else if (s == ((lg[k] + 2) & 7)) begin
                        acc   = 1;
                        st[k] = 2;
                    end else st[k] = 1;
                end
            endcase
            if (!exp_fl[5]) lg[k] = s;
            lr[k] = s;
        end
        exp_fl[6] = (acc == 0);
        w = '{conn: c.conn, payload: fill_data, dummy: 1'b1, cas_ok: 1'b0};
        repeat (n) exp_q.push_back(w);
        w = '{conn: c.conn, payload: c.payload, dummy: 1'b0, cas_ok: cas[0]};
        if (acc != 0) exp_q.push_back(w);
    endtask : predict

    // Watch the pins: words out, flags one cycle after each take.
    always @(posedge mclk) begin
        if (arst_n) begin
            if (out_valid && out_ready) begin
                if (exp_q.size() == 0) cmp_bit(1'b1, 1'b0);
                else cmp_word(out_cell, exp_q.pop_front());
            end
            cmp_flags({discard_flag, seq_gap_flag, misinsert_flag, lost_cell_flag, lost_count},
                      exp_fl);
            exp_fl = '0;
            if (in_valid && in_ready) predict(in_cell);
        end
    end

    // The receiver stalls at random, or fully while a scenario wants the buffer full.
    always @(posedge mclk) begin
        #1;
        out_ready <= (stall == 0) && ($urandom % 4 != 0);
    end

    // ------------------------------------------------------------
    // Stimulus helpers
    // ------------------------------------------------------------
    task automatic send(input int k, input int s);
        ssnc_pkg::ssnc_cell_t c;
        logic [383:0]         tmp;
        for (int j = 0; j < 12; j++) tmp[j*32+:32] = $urandom;
        c.conn    = k[3:0];
        c.sn      = s[2:0];
        c.sn_ok   = (s >= 0);
        c.payload = tmp[375:0];
        ssnc_src_i.q.push_back(c);
    endtask : send

    // Reset mid-run too, with words still queued, and check the boot cycle.
    task automatic do_reset;
        arst_n = 1'b0;
        ssnc_src_i.q.delete();
        repeat (10) @(posedge mclk);
        #1;
        cmp_bit(in_ready | out_valid | discard_flag | lost_cell_flag, 1'b0);
        foreach (st[k]) begin
            st[k] = 0;
            lr[k] = 0;
            lg[k] = 0;
        end
        exp_q.delete();
        exp_fl = '0;
        arst_n = 1'b1;
        #1;
        cmp_bit(in_ready, 1'b0);
        @(posedge mclk);
        #1;
        cmp_bit(in_ready, 1'b1);
        @(posedge mclk);
        #1;
        cmp_bit(in_ready, 1'b1);
    endtask : do_reset

    task automatic drain;
        for (int t = 0; t < 400 && (ssnc_src_i.q.size() != 0 || exp_q.size() != 0); t++) begin
            @(posedge mclk);
        end
        repeat (4) @(posedge mclk);
        cmp_bit(exp_q.size() == 0 && ssnc_src_i.q.size() == 0, 1'b1);
        #1;
    endtask : drain

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h7F6D));
        {arst_n, out_ready, stall, mismatches, checks_done} = '0;
        fill_data = ssnc_pkg::PAY_W'({12{32'h5A3C_96E1}});
        do_reset();
        // Three connections interleaved, buffer held full at first, losses filled later under random stalls.
        stall = 1;
        for (i = 0; i < 13; i++) begin
            if (i < seq_a.size()) send(1, seq_a[i]);
            if (i < seq_b.size()) send(2, seq_b[i]);
            if (i < seq_c.size()) send(3, seq_c[i]);
        end
        repeat (60) @(posedge mclk);
        stall = 0;
        drain();
        stall = 1;
        send(5, 1);
        send(5, 2);
        send(5, 3);
        repeat (20) @(posedge mclk);
        #1;
        do_reset();
        stall = 0;
        // Random cells, mostly one past each connection's last number at the start of the batch, fill data changed while idle.
        for (i = 0; i < 400; i++) begin
            if (i % 50 == 0) begin
                drain();
                fill_data = ssnc_pkg::PAY_W'({12{$urandom}});
            end
            send(i % 4, ($urandom % 10 == 0) ? -1 :
                 (($urandom % 3 != 0) ? (lr[i % 4] + 1) & 7 : $urandom % 8));
        end
        drain();
        give_verdict();
    end

    // Cut a hang short well beyond the expected length of the run.
    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end
endmodule : ssnc_fsm_bench
